// ==== hdl/dslc_cmd_if.sv ====
// decoded command class passed from the decoder to the lock controller
// assumes both ends share core_clk_in
interface dslc_cmd_if;
   logic is_security;
   logic is_set_pw;
   logic is_unlock;
   logic is_erase_prep;
   logic is_erase_unit;
   logic is_freeze;
   logic is_disable_pw;
   modport dec (output is_security, is_set_pw, is_unlock, is_erase_prep,
      is_erase_unit, is_freeze, is_disable_pw);
   modport ctl (input is_security, is_set_pw, is_unlock, is_erase_prep,
      is_erase_unit, is_freeze, is_disable_pw);
endinterface

// ==== hdl/dslc_decoder.sv ====
// opcode decoder for the security command group
// assumes opcode is stable whenever the controller samples it
module dslc_decoder (
   input wire logic [7:0] opcode_in, // ata command opcode
   dslc_cmd_if.dec cmd // decoded command class
);
   function automatic logic op_is(input logic [7:0] op, input logic [7:0] ref_op);
      op_is = (op == ref_op);
   endfunction

   assign cmd.is_set_pw = op_is(opcode_in, dslc_pkg::OP_SET_PW);
   assign cmd.is_unlock = op_is(opcode_in, dslc_pkg::OP_UNLOCK);
   assign cmd.is_erase_prep = op_is(opcode_in, dslc_pkg::OP_ERASE_PREP);
   assign cmd.is_erase_unit = op_is(opcode_in, dslc_pkg::OP_ERASE_UNIT);
   assign cmd.is_freeze = op_is(opcode_in, dslc_pkg::OP_FREEZE);
   assign cmd.is_disable_pw = op_is(opcode_in, dslc_pkg::OP_DISABLE_PW);
   assign cmd.is_security = cmd.is_set_pw | cmd.is_unlock | cmd.is_erase_prep |
      cmd.is_erase_unit | cmd.is_freeze | cmd.is_disable_pw;
endmodule

// ==== hdl/dslc_pkg.sv ====
// constants and types shared by the security lock controller and its helper
// assumes the command bus and password comparisons come from same-clock logic
// ----------------------------------------------------------------------------
// Contract
// - opcodes F1h..F6h form the security command group
// - security commands run only while trusted feature is manufactured-inactive
// - locked mode refuses media access until unlock or erase unit succeeds
// - no user password at power-on gives unlocked mode, all commands allowed
// - freeze lock enters frozen mode, left only by power removal; code also leaves it on hard reset (sys_rst_in)
// - frozen mode rejects lock-altering and password-setting commands
// - high level: correct master password on unlock unlocks without erase
// - maximum level: only erase unit with master password unlocks
// - master password alone never enables locking but may unlock
// - identify word 92 reports master revision code, valid 0001h..FFFEh
// - master revision code defaults to FFFEh as shipped
// - setting user password enables lock; locked at next reset
// - every unlock mismatch, master or user, bumps one shared counter
// - count 5 sets exhausted flag word 128 bit 4; aborts unlock, erase
// - counter and exhausted flag cleared by power-on or hard reset
// ----------------------------------------------------------------------------
package dslc_pkg;
   localparam logic [7:0] OP_SET_PW = 8'hF1;
   localparam logic [7:0] OP_UNLOCK = 8'hF2;
   localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
   localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
   localparam logic [7:0] OP_FREEZE = 8'hF5;
   localparam logic [7:0] OP_DISABLE_PW = 8'hF6;
   localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
   localparam logic [15:0] REV_MIN = 16'h0001;
   localparam logic [15:0] REV_MAX = 16'hFFFE;
   localparam int ATTEMPT_LIMIT = 5;
   localparam int CNT_W = 3;
   localparam int WORD_REV = 92;
   localparam int WORD_SEC = 128;
   localparam int SEC_SUPPORTED_BIT = 0;
   localparam int SEC_EXHAUSTED_BIT = 4;
   localparam int SEC_FROZEN_BIT = 3;
   localparam int SEC_LOCKED_BIT = 2;
   localparam int SEC_ENABLED_BIT = 1;
   localparam int SEC_LEVEL_BIT = 8;
   typedef enum logic [1:0] {
      DSLC_LOCKED,
      DSLC_UNLOCKED,
      DSLC_FROZEN
   } dslc_mode_e;
endpackage

// ==== hdl/dslc_top.sv ====
// security lock mode controller for a serial ata drive
// assumes command, passwords and compare results come from same-clock logic;
// sys_rst_in stands for power-on or hard reset; the password store is outside
module dslc_top (
   input wire logic core_clk_in, // system clock, 50 mhz
   input wire logic sys_rst_in, // power-on or hard reset, sync, high
   input wire logic cmd_valid_in, // one-cycle command strobe
   input wire logic [7:0] cmd_opcode_in, // command opcode
   input wire logic cmd_media_in, // command accesses media
   input wire logic cmd_master_in, // password field selects master
   input wire logic cmd_max_level_in, // set password: maximum level requested
   input wire logic [15:0] cmd_rev_in, // set master: new revision code
   input wire logic pw_match_in, // supplied password matches selected one
   input wire logic tcg_inactive_in, // trusted feature manufactured-inactive
   input wire logic user_pw_stored_in, // nonvolatile: user password present
   input wire logic max_level_stored_in, // nonvolatile: maximum level set
   input wire logic [15:0] rev_stored_in, // nonvolatile: master revision code
   output logic done_out, // one-cycle completion pulse
   output logic abort_out, // with done: aborted-command error
   output logic media_ok_out, // media access permitted
   output logic erase_out, // pulse: erase all user data
   output logic store_user_out, // pulse: store or clear user password
   output logic user_set_out, // value to store for user password presence
   output logic store_master_out, // pulse: store master password and code
   output logic max_level_out, // current security level is maximum
   output logic [1:0] mode_out, // current mode, see enum
   output logic [15:0] id_word_rev_out, // identify word 92
   output logic [15:0] id_word_sec_out // identify word 128
);
   dslc_cmd_if cmd ();

   dslc_decoder u_dec (
      .opcode_in(cmd_opcode_in),
      .cmd(cmd)
   );

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   dslc_pkg::dslc_mode_e mode_q, mode_d;
   logic [dslc_pkg::CNT_W-1:0] fail_cnt_q, fail_cnt_d;
   logic user_set_q, user_set_d;
   logic max_level_q, max_level_d;
   logic [15:0] rev_q, rev_d;
   logic boot_q;
   logic prepared_q, prepared_d;
   logic done_q, abort_q, erase_q, store_user_q, store_master_q, user_val_q;

   localparam logic [dslc_pkg::CNT_W-1:0] LIMIT =
      dslc_pkg::CNT_W'(dslc_pkg::ATTEMPT_LIMIT);
   localparam logic [dslc_pkg::CNT_W-1:0] ONE = dslc_pkg::CNT_W'(1);

   // ----------------------------------------------------------------------
   // command decision
   // ----------------------------------------------------------------------
   wire exhausted = (fail_cnt_q >= LIMIT);
   wire locked = (mode_q == dslc_pkg::DSLC_LOCKED);
   wire frozen = (mode_q == dslc_pkg::DSLC_FROZEN);
   wire take = cmd_valid_in & ~boot_q;
   wire sec_cmd = take & cmd.is_security;
   // trusted feature activated blocks the whole group
   wire tcg_block = sec_cmd & ~tcg_inactive_in;
   // frozen rejects password and lock changes
   wire frz_block = frozen & (cmd.is_set_pw | cmd.is_unlock | cmd.is_erase_prep |
      cmd.is_erase_unit | cmd.is_disable_pw);
   // locked rejects all but unlock, erase prepare and erase unit
   wire lck_block = locked & (cmd.is_set_pw | cmd.is_freeze | cmd.is_disable_pw);
   wire exp_block = exhausted & (cmd.is_unlock | cmd.is_erase_unit);
   // erase unit must follow an erase prepare
   wire prep_block = cmd.is_erase_unit & ~prepared_q;
   // media access refused while locked
   wire media_block = take & ~cmd.is_security & cmd_media_in & locked;
   wire gate_block = sec_cmd & (tcg_block | frz_block | lck_block | exp_block |
      prep_block);
   wire ok = sec_cmd & ~gate_block;
   // maximum level: master unlock not allowed, only erase unit
   wire lvl_block = cmd.is_unlock & cmd_master_in & max_level_q & user_set_q;
   wire pw_good = pw_match_in & ~lvl_block;
   wire needs_pw = cmd.is_unlock | cmd.is_erase_unit | cmd.is_disable_pw;
   wire pw_fail = ok & needs_pw & ~pw_good;
   wire unlock_fail = ok & cmd.is_unlock & ~pw_good;
   wire unlock_ok = ok & cmd.is_unlock & pw_good;
   wire erase_ok = ok & cmd.is_erase_unit & pw_good;
   wire set_user = ok & cmd.is_set_pw & ~cmd_master_in;
   wire set_master = ok & cmd.is_set_pw & cmd_master_in;
   wire dis_ok = ok & cmd.is_disable_pw & pw_good;
   wire rev_valid = (cmd_rev_in >= dslc_pkg::REV_MIN) &
      (cmd_rev_in <= dslc_pkg::REV_MAX);
   wire refused = media_block | gate_block | pw_fail;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      mode_d = mode_q;
      fail_cnt_d = fail_cnt_q;
      user_set_d = user_set_q;
      max_level_d = max_level_q;
      rev_d = rev_q;
      prepared_d = prepared_q;
      if (boot_q) begin
         // latch stored state after reset release
         user_set_d = user_pw_stored_in;
         max_level_d = max_level_stored_in;
         rev_d = rev_stored_in;
         mode_d = user_pw_stored_in ? dslc_pkg::DSLC_LOCKED : dslc_pkg::DSLC_UNLOCKED;
      end else begin
         if (take) begin
            prepared_d = ok & cmd.is_erase_prep;
         end
         case (mode_q)
            dslc_pkg::DSLC_LOCKED: begin
               if (unlock_ok | erase_ok) begin
                  mode_d = dslc_pkg::DSLC_UNLOCKED;
               end
            end
            dslc_pkg::DSLC_UNLOCKED: begin
               if (ok & cmd.is_freeze) begin
                  mode_d = dslc_pkg::DSLC_FROZEN;
               end
            end
            dslc_pkg::DSLC_FROZEN: begin
               mode_d = dslc_pkg::DSLC_FROZEN;
            end
            default: begin
               mode_d = dslc_pkg::DSLC_LOCKED;
            end
         endcase
         // saturating shared counter
         if (unlock_fail && fail_cnt_q < LIMIT) begin
            fail_cnt_d = fail_cnt_q + ONE;
         end
         if (set_user) begin
            user_set_d = 1'b1;
            max_level_d = cmd_max_level_in;
         end
         if (erase_ok | dis_ok) begin
            user_set_d = 1'b0;
            max_level_d = 1'b0;
         end
         if (set_master && rev_valid) begin
            rev_d = cmd_rev_in;
         end
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         mode_q <= dslc_pkg::DSLC_LOCKED;
         fail_cnt_q <= '0;
         user_set_q <= 1'b0;
         max_level_q <= 1'b0;
         rev_q <= dslc_pkg::REV_DEFAULT;
         boot_q <= 1'b1;
         prepared_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         fail_cnt_q <= fail_cnt_d;
         user_set_q <= user_set_d;
         max_level_q <= max_level_d;
         rev_q <= rev_d;
         boot_q <= 1'b0;
         prepared_q <= prepared_d;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         done_q <= 1'b0;
         abort_q <= 1'b0;
         erase_q <= 1'b0;
         store_user_q <= 1'b0;
         store_master_q <= 1'b0;
         user_val_q <= 1'b0;
      end else begin
         done_q <= take;
         abort_q <= take & refused;
         erase_q <= erase_ok;
         store_user_q <= set_user | erase_ok | dis_ok;
         store_master_q <= set_master;
         user_val_q <= set_user;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // identify word 128 bit fields
   logic [15:0] sec_word;
   always_comb begin
      sec_word = 16'h0000;
      sec_word[dslc_pkg::SEC_SUPPORTED_BIT] = 1'b1;
      sec_word[dslc_pkg::SEC_ENABLED_BIT] = user_set_q;
      sec_word[dslc_pkg::SEC_LOCKED_BIT] = locked;
      sec_word[dslc_pkg::SEC_FROZEN_BIT] = frozen;
      sec_word[dslc_pkg::SEC_EXHAUSTED_BIT] = exhausted;
      sec_word[dslc_pkg::SEC_LEVEL_BIT] = max_level_q;
   end

   assign done_out = done_q;
   assign abort_out = abort_q;
   assign erase_out = erase_q;
   assign store_user_out = store_user_q;
   assign user_set_out = user_val_q;
   assign store_master_out = store_master_q;
   assign max_level_out = max_level_q;
   assign mode_out = mode_q;
   assign media_ok_out = ~locked & ~boot_q;
   assign id_word_rev_out = rev_q;
   assign id_word_sec_out = sec_word;
endmodule

// ==== sim/dslc_host.sv ====
// host model: issues one security or media command at a time
// assumes dslc_top answers one cycle after the command is taken
module dslc_host (
   input wire logic core_clk_in, // system clock
   input wire logic [4:0] resp_in, // done, abort, erase, store user, user set
   output logic valid_out, // command strobe
   output logic [7:0] op_out, // opcode
   output logic media_out, // media access command
   output logic master_out, // master password selected
   output logic match_out, // supplied password matches
   output logic maxl_out, // maximum level requested
   output logic [15:0] rev_out // new master revision code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] r;
   initial {valid_out, op_out, media_out, master_out, match_out, maxl_out, rev_out} = '0;
   // fields stay put after the strobe drops, as a real host bus would
   task automatic issue(input logic [7:0] op, input logic md, ms, mt, ml,
      input logic [15:0] rv);
      @(posedge core_clk_in);
      valid_out <= 1'b1;
      op_out <= op;
      {media_out, master_out, match_out, maxl_out, rev_out} <= {md, ms, mt, ml, rv};
      @(posedge core_clk_in);
      valid_out <= 1'b0;
      #1 r = resp_in;
   endtask
endmodule

// ==== sim/dslc_top_sva.sv ====
// port checker for the security lock controller
// assumes one clock and the synchronous reset of dslc_top
module dslc_top_sva (
   input wire logic core_clk_in, // clock
   input wire logic sys_rst_in, // reset
   input wire logic cmd_valid_in, // strobe
   input wire logic [7:0] cmd_opcode_in, // opcode
   input wire logic cmd_media_in, // media command
   input wire logic tcg_inactive_in, // security allowed
   input wire logic done_out, // completion
   input wire logic abort_out, // aborted
   input wire logic media_ok_out, // media permitted
   input wire logic erase_out, // erase pulse
   input wire logic [1:0] mode_out, // mode
   input wire logic [15:0] id_word_rev_out, // word 92
   input wire logic [15:0] id_word_sec_out // word 128
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rst_q;
   logic take_q;
   // the boot cycle after reset ignores the strobe
   wire take = cmd_valid_in && !rst_q;
   wire sec = cmd_opcode_in >= dslc_pkg::OP_SET_PW && cmd_opcode_in <= dslc_pkg::OP_DISABLE_PW;
   wire frz = mode_out == dslc_pkg::DSLC_FROZEN;
   wire lck = mode_out == dslc_pkg::DSLC_LOCKED;
   wire exh = id_word_sec_out[dslc_pkg::SEC_EXHAUSTED_BIT];
   wire gate = cmd_opcode_in == dslc_pkg::OP_UNLOCK || cmd_opcode_in == dslc_pkg::OP_ERASE_UNIT;
   always_ff @(posedge core_clk_in) begin
      rst_q <= sys_rst_in;
      take_q <= take && !sys_rst_in;
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_done_timing: assert property (done_out == take_q) else $error("done timing");
   a_tcg_abort: assert property (take && sec && !tcg_inactive_in |=> done_out && abort_out)
      else $error("security cmd ran while trusted feature active");
   a_locked_media: assert property (take && cmd_media_in && lck |=> abort_out)
      else $error("media cmd ran while locked");
   a_media_unlocked: assert property (media_ok_out |-> !lck) else $error("media ok in locked");
   a_frozen_stays: assert property (frz |=> frz) else $error("left frozen mode");
   a_frozen_refuse: assert property (take && frz && sec && cmd_opcode_in != dslc_pkg::OP_FREEZE
      |=> abort_out) else $error("frozen did not refuse");
   a_exhaust_refuse: assert property (take && exh && gate |=> abort_out)
      else $error("exhausted did not refuse");
   a_exhaust_clear: assert property ($fell(exh) |-> $past(sys_rst_in))
      else $error("exhausted flag cleared without reset");
   a_erase_ok: assert property (erase_out |-> done_out && !abort_out
      && $past(cmd_opcode_in) == dslc_pkg::OP_ERASE_UNIT) else $error("stray erase");
   a_rev_range: assert property (id_word_rev_out >= dslc_pkg::REV_MIN
      && id_word_rev_out <= dslc_pkg::REV_MAX) else $error("revision code out of range");
   c_erase: cover property (erase_out);
   c_frozen: cover property (frz);
   c_exhaust: cover property ($rose(exh));
endmodule
bind dslc_top dslc_top_sva i_dslc_top_sva (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
   .cmd_valid_in(cmd_valid_in), .cmd_opcode_in(cmd_opcode_in), .cmd_media_in(cmd_media_in),
   .tcg_inactive_in(tcg_inactive_in), .done_out(done_out), .abort_out(abort_out),
   .media_ok_out(media_ok_out), .erase_out(erase_out), .mode_out(mode_out),
   .id_word_rev_out(id_word_rev_out), .id_word_sec_out(id_word_sec_out));

// ==== sim/dslc_top_tb.sv ====
// self-checking bench for dslc_top with the host model in front
// assumes nonvolatile state is set by the bench across each reset
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module dslc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] op; logic md, ms, mt, ab; logic [1:0] mode;} dslc_row_s;
   logic core_clk_in = 0;
   logic sys_rst_in = 1;
   logic tcg_q = 1;
   logic user_q = 1;
   logic maxl_q = 0;
   logic valid, media, master, match, maxl, done, abort, erase, stu, uset, stm, mlev, mok;
   logic [7:0] op;
   logic [15:0] rev, wrev, wsec;
   logic [1:0] mode;
   int err_total = 0;
   int n_tests = 0;
   // ------------------------------------------------------------
   // ordinary cases from locked, user password set, high level
   // ------------------------------------------------------------
   dslc_row_s rows [13] = '{
      {8'h25, 4'b1001, 2'h0}, {8'hF1, 4'b0011, 2'h0}, {8'hF5, 4'b0011, 2'h0},
      {8'hF2, 4'b0001, 2'h0}, {8'hF2, 4'b0110, 2'h1}, {8'h25, 4'b1000, 2'h1},
      {8'hF1, 4'b0110, 2'h1}, {8'hF5, 4'b0000, 2'h2}, {8'hF2, 4'b0011, 2'h2},
      {8'hF1, 4'b0011, 2'h2}, {8'hF6, 4'b0011, 2'h2}, {8'hF3, 4'b0011, 2'h2},
      {8'h25, 4'b1000, 2'h2}};
   always #10 core_clk_in = ~core_clk_in;
   dslc_host i_dslc_host (.core_clk_in(core_clk_in), .resp_in({done, abort, erase, stu, uset}),
      .valid_out(valid), .op_out(op), .media_out(media), .master_out(master),
      .match_out(match), .maxl_out(maxl), .rev_out(rev));
   dslc_top i_dslc_top (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .cmd_valid_in(valid), .cmd_opcode_in(op), .cmd_media_in(media), .cmd_master_in(master),
      .cmd_max_level_in(maxl), .cmd_rev_in(rev), .pw_match_in(match),
      .tcg_inactive_in(tcg_q), .user_pw_stored_in(user_q), .max_level_stored_in(maxl_q),
      .rev_stored_in(16'h1234), .done_out(done), .abort_out(abort), .media_ok_out(mok),
      .erase_out(erase), .store_user_out(stu), .user_set_out(uset), .store_master_out(stm),
      .max_level_out(mlev), .mode_out(mode), .id_word_rev_out(wrev), .id_word_sec_out(wsec));
   task automatic do_reset(input logic up, ml);
      user_q <= up;
      maxl_q <= ml;
      sys_rst_in <= 1'b1;
      repeat (20) @(posedge core_clk_in);
      #1 `CHK("rst rev", 16'hFFFE, wrev)
      @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge core_clk_in);
      // settle past the boot edge so state outputs show latched values
      #1;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      do_reset(1'b1, 1'b0);
      `CHK("boot rev", 16'h1234, wrev)
      foreach (rows[i]) begin
         i_dslc_host.issue(rows[i].op, rows[i].md, rows[i].ms, rows[i].mt, 1'b0, 16'h0042);
         `CHK("resp", {1'b1, rows[i].ab}, i_dslc_host.r[4:3])
         `CHK("mode", rows[i].mode, mode)
      end
      `CHK("rev new", 16'h0042, wrev)
      do_reset(1'b0, 1'b0);
      `CHK("no pw mode", 2'h1, mode)
      tcg_q <= 1'b0;
      i_dslc_host.issue(8'hF5, 0, 0, 0, 0, 16'h0001);
      `CHK("tcg abort", 2'b11, i_dslc_host.r[4:3])
      tcg_q <= 1'b1;
      // master first, then user password
      i_dslc_host.issue(8'hF1, 0, 1, 1, 0, 16'h0007);
      `CHK("master store", 1'b1, stm)
      `CHK("master no lock", 1'b0, wsec[1])
      // out-of-range code keeps the old one
      i_dslc_host.issue(8'hF1, 0, 1, 1, 0, 16'hFFFF);
      `CHK("rev kept", 16'h0007, wrev)
      i_dslc_host.issue(8'hF1, 0, 0, 1, 0, 16'h0007);
      `CHK("user set", 3'b011, i_dslc_host.r[2:0])
      `CHK("lock enabled", 1'b1, wsec[1])
      i_dslc_host.issue(8'hF6, 0, 0, 1, 0, 16'h0007);
      `CHK("pw disabled", 3'b010, i_dslc_host.r[2:0])
      do_reset(1'b1, 1'b0);
      `CHK("relock", 2'h0, mode)
      `CHK("sec word", 16'h0007, wsec)
      `CHK("media locked", 1'b0, mok)
      // eight misses: counter must not wrap back to a permissive value
      repeat (8) i_dslc_host.issue(8'hF2, 0, 0, 0, 0, 16'h0001);
      `CHK("exhausted", 1'b1, wsec[4])
      i_dslc_host.issue(8'hF2, 0, 0, 1, 0, 16'h0001);
      `CHK("exh unlock", 1'b1, i_dslc_host.r[3])
      do_reset(1'b1, 1'b0);
      `CHK("exh clear", 1'b0, wsec[4])
      i_dslc_host.issue(8'hF2, 0, 0, 1, 0, 16'h0001);
      `CHK("unlock ok", 2'b10, i_dslc_host.r[4:3])
      `CHK("media open", 1'b1, mok)
      do_reset(1'b1, 1'b1);
      `CHK("max level", 1'b1, mlev)
      `CHK("max sec word", 16'h0107, wsec)
      i_dslc_host.issue(8'hF2, 0, 1, 1, 0, 16'h0001);
      `CHK("max master", 1'b1, i_dslc_host.r[3])
      i_dslc_host.issue(8'hF4, 0, 1, 1, 0, 16'h0001);
      `CHK("no prep", 1'b1, i_dslc_host.r[3])
      i_dslc_host.issue(8'hF3, 0, 1, 1, 0, 16'h0001);
      i_dslc_host.issue(8'hF4, 0, 1, 1, 0, 16'h0001);
      `CHK("erase", 3'b101, i_dslc_host.r[4:2])
      `CHK("erase mode", 2'h1, mode)
      tally_and_finish();
   end
endmodule
